// File: logic/calendar_clock.sv
// Calendar clock with summer-time correction, sleep control and APB registers.
// Assumes a synchronous APB master on mclk and level battery and sleep inputs.
`timescale 1ns/1ps
module calendar_clock #(
  parameter int unsigned TICK_CYCLES = clock_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clock_pkg::ADDR_W-1:0] paddr,
  input wire logic [clock_pkg::DATA_W-1:0] pwdata,
  output logic [clock_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic batteryLost,
  input wire logic sleepRequest,
  output logic sleepActive,
  output logic clockUnsetFault,
  output logic irq
);
  import clock_pkg::*;

  // Calendar state
  logic [5:0] sec_q;
  logic [5:0] min_q;
  logic [3:0] hour_q;
  logic pm_q;
  logic [4:0] day_q;
  logic [3:0] month_q;
  logic [6:0] year_q;
  logic [2:0] wday_q;

  // Settings
  logic [2:0] ctrl_q;
  logic [26:0] begin_q;
  logic [26:0] finish_q;
  logic [6:0] offset_q;
  logic [IRQ_W-1:0] irqStat_q;
  logic [IRQ_W-1:0] irqMask_q;
  logic timeLoaded_q;
  logic dateLoaded_q;
  logic beginDone_q;
  logic finishDone_q;

  // Bus
  logic ready_q;
  logic err_q;
  logic [DATA_W-1:0] rdata_q;
  logic access;
  logic wrDone;
  logic hit;
  logic [DATA_W-1:0] readMux;
  logic wrCtrl;
  logic wrTime;
  logic wrDate;
  logic wrBegin;
  logic wrFinish;
  logic wrOffset;
  logic wrIrqStat;
  logic wrIrqMask;

  // Event and carry terms
  logic tick;
  logic clearNow;
  logic unset;
  logic secWrap;
  logic minWrap;
  logic dayWrap;
  logic monWrap;
  logic yearWrap;
  logic beginHit;
  logic finishHit;
  logic adjustNow;
  logic [3:0] shiftHour;
  logic shiftPm;
  logic [5:0] shiftMin;
  logic [IRQ_W-1:0] irqEvents;

  second_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .mclk(mclk),
    .srst(srst),
    .secondTick_q(tick)
  );

  // APB: one wait state, so read data always comes from a register
  assign access = psel && penable && !ready_q;
  assign wrDone = psel && penable && ready_q && pwrite && hit;
  assign pready = ready_q;
  assign prdata = rdata_q;
  assign pslverr = ready_q && err_q;

  always_comb begin
    hit = 1'b1;
    readMux = '0;
    case (paddr)
      CTRL_OFS: readMux = 32'(ctrl_q);
      TIME_OFS: readMux = (32'(sec_q) << TIME_SEC_LSB) | (32'(min_q) << TIME_MIN_LSB)
                          | (32'(hour_q) << TIME_HOUR_LSB) | (32'(pm_q) << TIME_PM_BIT);
      DATE_OFS: readMux = (32'(day_q) << DATE_DAY_LSB) | (32'(month_q) << DATE_MON_LSB)
                          | (32'(year_q) << DATE_YEAR_LSB) | (32'(wday_q) << DATE_WDAY_LSB);
      BEGIN_OFS: readMux = 32'(begin_q);
      FINISH_OFS: readMux = 32'(finish_q);
      OFFSET_OFS: readMux = 32'(offset_q);
      IRQ_STAT_OFS: readMux = 32'(irqStat_q);
      IRQ_MASK_OFS: readMux = 32'(irqMask_q);
      STATUS_OFS: readMux = {27'h0, finishDone_q, beginDone_q, sleepActive, unset,
                             clockUnsetFault};
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    wrCtrl = wrDone && (paddr == CTRL_OFS);
    wrTime = wrDone && (paddr == TIME_OFS);
    wrDate = wrDone && (paddr == DATE_OFS);
    wrBegin = wrDone && (paddr == BEGIN_OFS);
    wrFinish = wrDone && (paddr == FINISH_OFS);
    wrOffset = wrDone && (paddr == OFFSET_OFS);
    wrIrqStat = wrDone && (paddr == IRQ_STAT_OFS);
    wrIrqMask = wrDone && (paddr == IRQ_MASK_OFS);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ready_q <= access;
      if (access) begin
        err_q <= !hit;
        rdata_q <= pwrite ? '0 : readMux;
      end
    end
  end

  // Settings registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      begin_q <= MOMENT_RST;
      finish_q <= MOMENT_RST;
      offset_q <= OFFSET_RST;
      irqMask_q <= IRQ_RST;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= pwdata[2:0];
      end
      if (wrBegin) begin
        begin_q <= pwdata[26:0];
      end
      if (wrFinish) begin
        finish_q <= pwdata[26:0];
      end
      if (wrOffset) begin
        offset_q <= (pwdata[6:0] > OFFSET_MAX) ? OFFSET_MAX : pwdata[6:0];
      end
      if (wrIrqMask) begin
        irqMask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Sleep is refused while scheduling needs the clock
  assign sleepActive = sleepRequest && !ctrl_q[CTRL_SCHED_BIT];
  assign clearNow = batteryLost || sleepActive;

  // Carry chain of one tick
  always_comb begin
    secWrap = (sec_q == SEC_LAST);
    minWrap = secWrap && (min_q == MIN_LAST);
    dayWrap = minWrap && (hour_q == HOUR_ELEVEN) && pm_q;
    monWrap = dayWrap && (day_q >= lastDay(month_q, year_q));
    yearWrap = monWrap && (month_q >= MON_LAST);
  end

  // Summer-time moments; occurrence 0 means the first instance
  function automatic logic momentHit(input logic [26:0] m);
    logic [2:0] occ;
    occ = (m[MOM_OCC_LSB +: 3] == 3'h0) ? 3'h1 : m[MOM_OCC_LSB +: 3];
    momentHit = (month_q == m[MOM_MON_LSB +: 4]) && (wday_q == m[MOM_WDAY_LSB +: 3])
                && (occurrence(day_q) == occ) && (hour_q == m[MOM_HOUR_LSB +: 4])
                && !pm_q && (min_q == 6'h00) && (sec_q == 6'h00);
  endfunction

  always_comb begin
    beginHit = ctrl_q[CTRL_SUMMER_BIT] && !beginDone_q && momentHit(begin_q);
    finishHit = ctrl_q[CTRL_SUMMER_BIT] && !finishDone_q && momentHit(finish_q);
    adjustNow = (beginHit || finishHit) && !tick && !clearNow && !wrTime && !wrDate;
  end

  minute_shift u_shift (
    .hourIn(hour_q),
    .pmIn(pm_q),
    .minIn(min_q),
    .amount(offset_q),
    .forward(beginHit),
    .hourOut(shiftHour),
    .pmOut(shiftPm),
    .minOut(shiftMin)
  );

  // Time of day
  always_ff @(posedge mclk) begin
    if (srst || clearNow) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hour_q <= 4'h0;
      pm_q <= 1'b0;
    end else if (wrTime) begin
      sec_q <= pwdata[TIME_SEC_LSB +: 6];
      min_q <= pwdata[TIME_MIN_LSB +: 6];
      hour_q <= pwdata[TIME_HOUR_LSB +: 4];
      pm_q <= pwdata[TIME_PM_BIT];
    end else if (adjustNow) begin
      min_q <= shiftMin;
      hour_q <= shiftHour;
      pm_q <= shiftPm;
    end else if (tick) begin
      sec_q <= secWrap ? 6'h00 : sec_q + 6'h01;
      if (secWrap) begin
        min_q <= (min_q == MIN_LAST) ? 6'h00 : min_q + 6'h01;
      end
      if (minWrap) begin
        if (hour_q == HOUR_ELEVEN) begin
          hour_q <= HOUR_NOON;
          pm_q <= !pm_q;
        end else if (hour_q >= HOUR_NOON || hour_q == 4'h0) begin
          hour_q <= 4'h1;
        end else begin
          hour_q <= hour_q + 4'h1;
        end
      end
    end
  end

  // Date
  always_ff @(posedge mclk) begin
    if (srst || clearNow) begin
      day_q <= 5'h00;
      month_q <= 4'h0;
      year_q <= 7'h00;
      wday_q <= 3'h0;
    end else if (wrDate) begin
      day_q <= pwdata[DATE_DAY_LSB +: 5];
      month_q <= pwdata[DATE_MON_LSB +: 4];
      year_q <= pwdata[DATE_YEAR_LSB +: 7];
      wday_q <= pwdata[DATE_WDAY_LSB +: 3];
    end else if (tick && dayWrap) begin
      wday_q <= (wday_q >= WDAY_LAST) ? 3'h1 : wday_q + 3'h1;
      day_q <= monWrap ? 5'h01 : day_q + 5'h01;
      if (monWrap) begin
        month_q <= yearWrap ? 4'h1 : month_q + 4'h1;
      end
      if (yearWrap) begin
        year_q <= (year_q >= YEAR_LAST) ? 7'h00 : year_q + 7'h01;
      end
    end
  end

  // Once-per-year guards; a new year or a new date rearms both
  always_ff @(posedge mclk) begin
    if (srst || clearNow || wrDate || (tick && yearWrap)) begin
      beginDone_q <= 1'b0;
      finishDone_q <= 1'b0;
    end else if (adjustNow) begin
      if (beginHit) begin
        beginDone_q <= 1'b1;
      end else begin
        finishDone_q <= 1'b1;
      end
    end
  end

  // Clock-set tracking: both halves must be loaded after a clear
  always_ff @(posedge mclk) begin
    if (srst || clearNow) begin
      timeLoaded_q <= 1'b0;
      dateLoaded_q <= 1'b0;
    end else begin
      if (wrTime) begin
        timeLoaded_q <= 1'b1;
      end
      if (wrDate) begin
        dateLoaded_q <= 1'b1;
      end
    end
  end

  assign unset = !(timeLoaded_q && dateLoaded_q);
  assign clockUnsetFault = unset && ctrl_q[CTRL_SCHED_BIT] && ctrl_q[CTRL_CHECK_BIT];

  // Sticky events; a new event wins over a write-one-to-clear in the same cycle
  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_CLEARED_BIT] = clearNow;
    irqEvents[IRQ_BEGIN_BIT] = adjustNow && beginHit;
    irqEvents[IRQ_FINISH_BIT] = adjustNow && !beginHit;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irqStat_q <= IRQ_RST;
    end else begin
      irqStat_q <= (irqStat_q & ~(wrIrqStat ? pwdata[IRQ_W-1:0] : IRQ_RST)) | irqEvents;
    end
  end

  assign irq = |(irqStat_q & irqMask_q);
endmodule // calendar_clock

// File: logic/clock_pkg.sv
// Register map, field layout, limits and calendar helpers of the calendar clock.
// Assumes one 100 MHz clock and an APB master with 32-bit data and byte addresses.
// How it works
// - Seconds, minutes, hours, day, month, weekday and year count on, and February has 29 days in leap years.
// - Hours run 1 to 12 and a separate PM bit flips each time the hour count goes from eleven to twelve.
// - Battery loss or sleep clears the time to 00:00 AM and the date to 00/00/00.
// - The clock-unset fault shows while the clock is cleared and both scheduling and clock checking are on.
// - With summer time on, reaching the begin moment adds the offset to the time.
// - With summer time on, reaching the finish moment subtracts the offset from the time.
// - With summer time off, the clock runs with no correction.
// - The offset takes 0 to 120 minutes and serves both corrections.
// - Begin and finish hours are separate settings, 1 to 12, always morning hours.
// - Begin and finish months are separate settings, 1 to 12.
// - Begin and finish weekdays are separate settings, Monday to Sunday.
// - Begin and finish occurrences pick which instance of the weekday in the month counts.
// - Sleep is refused while the exercise schedule is enabled.
package clock_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 3;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIME_OFS = 8'h04;
  localparam logic [7:0] DATE_OFS = 8'h08;
  localparam logic [7:0] BEGIN_OFS = 8'h0C;
  localparam logic [7:0] FINISH_OFS = 8'h10;
  localparam logic [7:0] OFFSET_OFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
  localparam logic [7:0] STATUS_OFS = 8'h20;

  localparam int CTRL_SCHED_BIT = 0;
  localparam int CTRL_CHECK_BIT = 1;
  localparam int CTRL_SUMMER_BIT = 2;
  localparam int TIME_SEC_LSB = 0;
  localparam int TIME_MIN_LSB = 8;
  localparam int TIME_HOUR_LSB = 16;
  localparam int TIME_PM_BIT = 24;
  localparam int DATE_DAY_LSB = 0;
  localparam int DATE_MON_LSB = 8;
  localparam int DATE_YEAR_LSB = 16;
  localparam int DATE_WDAY_LSB = 24;
  localparam int MOM_HOUR_LSB = 0;
  localparam int MOM_WDAY_LSB = 8;
  localparam int MOM_MON_LSB = 16;
  localparam int MOM_OCC_LSB = 24;
  localparam int IRQ_CLEARED_BIT = 0;
  localparam int IRQ_BEGIN_BIT = 1;
  localparam int IRQ_FINISH_BIT = 2;

  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [26:0] MOMENT_RST = 27'h0;
  localparam logic [6:0] OFFSET_RST = 7'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [3:0] HOUR_NOON = 4'hC;
  localparam logic [3:0] HOUR_ELEVEN = 4'hB;
  localparam logic [3:0] MON_LAST = 4'hC;
  localparam logic [6:0] YEAR_LAST = 7'h63;
  localparam logic [2:0] WDAY_LAST = 3'h7;
  localparam logic [6:0] OFFSET_MAX = 7'h78;
  localparam logic [10:0] DAY_MINUTES_LAST = 11'h59F;
  localparam logic [10:0] HOUR_MINUTES = 11'h03C;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  function automatic logic [4:0] lastDay(input logic [3:0] mon, input logic [6:0] yr);
    case (mon)
      4'h2: lastDay = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: lastDay = 5'h1E;
      default: lastDay = 5'h1F;
    endcase
  endfunction

  function automatic logic [2:0] occurrence(input logic [4:0] day);
    occurrence = 3'(({1'b0, day} + 6'h06) / 6'h07);
  endfunction
endpackage

// File: logic/minute_shift.sv
// Moves a 12-hour time of day forward or back by a number of minutes.
// Assumes inputs are in range; the result stays inside the same day.
`timescale 1ns/1ps
module minute_shift (
  input wire logic [3:0] hourIn,
  input wire logic pmIn,
  input wire logic [5:0] minIn,
  input wire logic [6:0] amount,
  input wire logic forward,
  output logic [3:0] hourOut,
  output logic pmOut,
  output logic [5:0] minOut
);
  import clock_pkg::*;
  logic [10:0] dayMin;
  logic [10:0] shifted;
  logic [4:0] h24;
  logic [3:0] h12;

  always_comb begin
    h24 = {1'b0, (hourIn == HOUR_NOON) ? 4'h0 : hourIn} + (pmIn ? 5'h0C : 5'h00);
    dayMin = 11'(h24) * HOUR_MINUTES + 11'(minIn);
    // Crossing midnight would need a date step; the correction saturates instead
    if (forward) begin
      shifted = (dayMin + 11'(amount) > DAY_MINUTES_LAST) ? DAY_MINUTES_LAST
                : dayMin + 11'(amount);
    end else begin
      shifted = (dayMin < 11'(amount)) ? 11'h000 : dayMin - 11'(amount);
    end
    h24 = 5'(shifted / HOUR_MINUTES);
    minOut = 6'(shifted % HOUR_MINUTES);
    pmOut = (h24 >= 5'h0C);
    h12 = pmOut ? 4'(h24 - 5'h0C) : h24[3:0];
    hourOut = (h12 == 4'h0) ? HOUR_NOON : h12;
  end
endmodule // minute_shift

// File: logic/second_tick.sv
// One-cycle pulse every CYCLES clocks, the time base of the calendar.
// Assumes mclk runs free; the count restarts on srst.
`timescale 1ns/1ps
module second_tick #(
  parameter int unsigned CYCLES = clock_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  output logic secondTick_q
);
  import clock_pkg::*;
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      count_q <= '0;
      secondTick_q <= 1'b0;
    end else if (count_q == LAST) begin
      count_q <= '0;
      secondTick_q <= 1'b1;
    end else begin
      count_q <= count_q + W'(1);
      secondTick_q <= 1'b0;
    end
  end
endmodule // second_tick

// File: verification/calendar_clock_sva.sv
// Checker for calendar_clock: APB timing, clearing, fault, sleep and interrupt relations.
// Assumes it is bound into calendar_clock and shadows the CTRL and mask writes itself.
`timescale 1ns/1ps
module calendar_clock_sva #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clock_pkg::ADDR_W-1:0] paddr,
  input wire logic [clock_pkg::DATA_W-1:0] pwdata,
  input wire logic [clock_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic batteryLost,
  input wire logic sleepRequest,
  input wire logic sleepActive,
  input wire logic clockUnsetFault,
  input wire logic irq
);
  import clock_pkg::*;
  logic [2:0] ctrlShadow_q;
  logic [2:0] maskShadow_q;
  logic wrDone;
  logic ctrlWr;
  assign wrDone = psel && penable && pready && pwrite;
  assign ctrlWr = wrDone && (paddr == CTRL_OFS);
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrlShadow_q <= 3'h0;
    end else if (ctrlWr) begin
      ctrlShadow_q <= pwdata[2:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      maskShadow_q <= 3'h0;
    end else if (wrDone && (paddr == IRQ_MASK_OFS)) begin
      maskShadow_q <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  ready_wait_a: assert property (
    psel && penable && !pready |=> pready) else $error("no answer after one wait state");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("ready held past one cycle");
  unmapped_err_a: assert property (
    pready && (paddr > STATUS_OFS) |-> pslverr && (prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    pready && (paddr <= STATUS_OFS) && (paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped access refused");
  sleep_gate_a: assert property (
    sleepActive == (sleepRequest && !ctrlShadow_q[CTRL_SCHED_BIT]))
    else $error("sleep not gated by schedule enable");
  clear_fault_a: assert property (
    batteryLost && (ctrlShadow_q[1:0] == 2'h3) && !ctrlWr |=> clockUnsetFault)
    else $error("fault missing after battery loss");
  fault_enables_a: assert property (
    clockUnsetFault |-> ctrlShadow_q[CTRL_SCHED_BIT] && ctrlShadow_q[CTRL_CHECK_BIT])
    else $error("fault without both enables");
  fault_holds_a: assert property (
    clockUnsetFault && !wrDone |=> clockUnsetFault) else $error("fault dropped by itself");
  fault_stays_clear_a: assert property (
    !clockUnsetFault && !batteryLost && !sleepActive && !ctrlWr |=> !clockUnsetFault)
    else $error("fault rose without a clear");
  clear_irq_a: assert property (
    batteryLost && maskShadow_q[IRQ_CLEARED_BIT] |=> irq) else $error("no clear interrupt");
  cover property (batteryLost ##1 clockUnsetFault);
  cover property (pready && pslverr);
  cover property (sleepActive);
  cover property ($rose(irq));
endmodule // calendar_clock_sva

bind calendar_clock calendar_clock_sva #(.TICK_CYCLES(TICK_CYCLES)) checkerInst (
  .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .batteryLost(batteryLost), .sleepRequest(sleepRequest), .sleepActive(sleepActive),
  .clockUnsetFault(clockUnsetFault), .irq(irq)
);

// File: verification/tb.sv
// Self-checking bench for calendar_clock: APB tasks and one task per scenario.
// Assumes a 100 MHz clock and a ten-cycle second so roll-overs come quickly.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      failCount++; \
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb;
  import clock_pkg::*;
  localparam int unsigned TICKS = 10;
  localparam logic [31:0] RT [5] = '{32'h010B3B3B, 32'h010B3B3B, 32'h010B3B3B,
    32'h000B3B3B, 32'h010B3B3B};
  localparam logic [31:0] RD [5] = '{32'h0304021C, 32'h0305021C, 32'h07630C1F,
    32'h0101010A, 32'h0201041E};
  localparam logic [31:0] XT [5] = '{32'h000C0000, 32'h000C0000, 32'h000C0000,
    32'h010C0000, 32'h000C0000};
  localparam logic [31:0] XD [5] = '{32'h0404021D, 32'h04050301, 32'h01000101,
    32'h0101010A, 32'h03010501};
  localparam logic [31:0] SC [4] = '{32'h0, 32'h4, 32'h4, 32'h4};
  localparam logic [31:0] SB [4] = '{32'h01040302, 32'h01040302, 32'h01050302, 32'h01040302};
  localparam logic [31:0] SF [4] = '{32'h00040303, 32'h02040303, 32'h00040303, 32'h00040303};
  localparam logic [31:0] ST [4] = '{32'h00013B3B, 32'h00013B3B, 32'h00023B3B, 32'h00013B3B};
  localparam logic [31:0] SX [4] = '{32'h00020000, 32'h00030000, 32'h00020000, 32'h00020000};
  localparam logic [1:0] SS [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic batteryLost = 1'b0;
  logic sleepRequest = 1'b0;
  logic sleepActive;
  logic clockUnsetFault;
  logic irq;
  int failCount = 0;
  int checked = 0;

  calendar_clock #(.TICK_CYCLES(TICKS)) dut (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .batteryLost(batteryLost), .sleepRequest(sleepRequest), .sleepActive(sleepActive),
    .clockUnsetFault(clockUnsetFault), .irq(irq)
  );

  always #5 mclk = ~mclk;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failCount++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(CTRL_OFS, r);
    `CHK(r, 32'h0)
    apb(1'b0, 8'h24, 32'h0, r, e);
    `CHK({e, r}, 33'h100000000)
    apb(1'b1, 8'h40, 32'h7, r, e);
    `CHK(e, 1'b1)
    // A refused write must not alias onto the control bits
    rd(CTRL_OFS, r);
    `CHK(r, 32'h0)
    wr(OFFSET_OFS, 32'h7F);
    rd(OFFSET_OFS, r);
    `CHK(r, 32'h78)
    wr(OFFSET_OFS, 32'h3C);
  endtask

  task automatic t_roll();
    logic [31:0] r;
    int n;
    for (int i = 0; i < 5; i++) begin
      wr(DATE_OFS, RD[i]);
      wr(TIME_OFS, RT[i]);
      n = 0;
      do begin
        rd(TIME_OFS, r);
        n++;
      end while (r === RT[i] && n < 10);
      `CHK(r, XT[i])
      rd(DATE_OFS, r);
      `CHK(r, XD[i])
    end
  endtask

  task automatic t_clear();
    logic [31:0] r;
    wr(IRQ_MASK_OFS, 32'h1);
    wr(CTRL_OFS, 32'h3);
    wr(IRQ_STAT_OFS, 32'h7);
    batteryLost <= 1'b1;
    @(posedge mclk);
    batteryLost <= 1'b0;
    @(posedge mclk);
    `CHK({clockUnsetFault, irq}, 2'h3)
    rd(TIME_OFS, r);
    `CHK(r & 32'h01FFFF00, 32'h0)
    rd(DATE_OFS, r);
    `CHK(r & 32'h007F0F1F, 32'h0)
    wr(IRQ_STAT_OFS, 32'h1);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(TIME_OFS, 32'h00010000);
    @(posedge mclk);
    `CHK(clockUnsetFault, 1'b1)
    wr(DATE_OFS, 32'h01010101);
    @(posedge mclk);
    `CHK(clockUnsetFault, 1'b0)
    sleepRequest <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    `CHK({sleepActive, clockUnsetFault}, 2'h0)
    wr(CTRL_OFS, 32'h0);
    @(posedge mclk);
    `CHK(sleepActive, 1'b1)
    sleepRequest <= 1'b0;
    wr(CTRL_OFS, 32'h3);
    @(posedge mclk);
    `CHK(clockUnsetFault, 1'b1)
  endtask

  task automatic t_summer();
    logic [31:0] r;
    int n;
    wr(IRQ_MASK_OFS, 32'h6);
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_OFS, SC[i]);
      wr(BEGIN_OFS, SB[i]);
      wr(FINISH_OFS, SF[i]);
      wr(DATE_OFS, 32'h03010401);
      wr(IRQ_STAT_OFS, 32'h7);
      wr(TIME_OFS, ST[i]);
      n = 0;
      do begin
        rd(TIME_OFS, r);
        n++;
      end while (!(r[5:0] >= 6'h02 && r[5:0] <= 6'h14) && n < 30);
      `CHK(r & 32'h01FFFF00, SX[i])
      rd(STATUS_OFS, r);
      `CHK({r[4:3], irq}, {SS[i], |SS[i]})
    end
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    failCount++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_roll();
    t_clear();
    t_summer();
    print_verdict();
  end
endmodule // tb
